// >>> pmt_pkg.sv
// Purpose: Shared constants for the periodic timer block.
// Assumes: 32-bit classic Wishbone register access.
// Notes: Offsets are byte addresses of aligned words.
package pmt_pkg;
  localparam int PMT_CNT_W = 10;
  localparam int PMT_DIV_W = 8;

  localparam logic [7:0] PMT_ADR_CTRL = 8'h00;
  localparam logic [7:0] PMT_ADR_CNT = 8'h04;
  localparam logic [7:0] PMT_ADR_COMPARE_A_VALUE = 8'h08;
  localparam logic [7:0] PMT_ADR_COMPARE_P_VALUE = 8'h0c;
  localparam logic [7:0] PMT_ADR_FLAG = 8'h10;
  localparam logic [7:0] PMT_ADR_DIV = 8'h14;

  localparam int PMT_CTRL_RUN = 0;
  localparam int PMT_CTRL_MODE = 1;
  localparam int PMT_CTRL_IO = 3;
  localparam int PMT_CTRL_OC = 5;
  localparam int PMT_CTRL_POL = 6;
  localparam int PMT_CTRL_CAPTS = 7;
  localparam int PMT_CTRL_CCLR = 8;
  localparam int PMT_FLAG_A = 0;
  localparam int PMT_FLAG_P = 1;

  localparam logic [9:0] PMT_CCR_RST = 10'h000;
  localparam logic [7:0] PMT_DIV_RST = 8'h00;
  localparam logic [9:0] PMT_CNT_MAX = 10'h3ff;
  localparam logic [10:0] PMT_PERIOD_FULL = 11'h400;

  typedef enum logic [1:0] {
    PMT_MODE_CMP = 2'b00,
    PMT_MODE_CAP = 2'b01,
    PMT_MODE_PWM = 2'b10,
    PMT_MODE_TMR = 2'b11
  } pmt_mode_t;

  // Compare-match pin actions
  localparam logic [1:0] PMT_IO_KEEP = 2'h0;
  localparam logic [1:0] PMT_IO_LOW = 2'h1;
  localparam logic [1:0] PMT_IO_HIGH = 2'h2;
  localparam logic [1:0] PMT_IO_TOG = 2'h3;
  // Capture edge selects
  localparam logic [1:0] PMT_IO_RISE = 2'h0;
  localparam logic [1:0] PMT_IO_FALL = 2'h1;
  localparam logic [1:0] PMT_IO_BOTH = 2'h2;
  localparam logic [1:0] PMT_IO_NOCAP = 2'h3;
  // PWM-mode output selects
  localparam logic [1:0] PMT_IO_FORCE_LO = 2'h0;
  localparam logic [1:0] PMT_IO_FORCE_HI = 2'h1;
  localparam logic [1:0] PMT_IO_PWM = 2'h2;
  localparam logic [1:0] PMT_IO_PULSE = 2'h3;
endpackage

// >>> pmt_tick_div.sv
// Purpose: Timer clock enable divider.
// Assumes: One system clock.
// Notes: Tick every div_i+1 cycles.
`timescale 1ns/1ns
`default_nettype none
module pmt_tick_div
  import pmt_pkg::*;
#(
  parameter int DIV_W = PMT_DIV_W
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic tick_o
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } pmt_div_state_t;

  pmt_div_state_t s;
  pmt_div_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt >= div_i) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;
endmodule
`default_nettype wire

// >>> pmt_timer.sv
// Purpose: Periodic timer with compare, PWM, single pulse and capture modes.
// Assumes: Pins synchronous to clk_i; classic Wishbone slave, 32-bit data.
// Notes: Registers CTRL, CNT, COMPARE_A_VALUE, COMPARE_P_VALUE, FLAG, DIV.
// What this block does
// - Mode 11 counts and flags like compare mode, output pin released.
// - PWM: comparator P sets period, comparator A sets duty.
// - PWM period equals P value, or 1024 counts when P is zero.
// - Duty at or above period holds output permanently active.
// - PWM sets A flag on A match and P flag at period end, when the counter reaches P value minus one.
// - Action field enables PWM or forces pin; counting continues.
// - Level control picks active level; polarity bit inverts the pin except when the action field forces it low or high.
// - Clear source select is ignored in PWM mode.
// - Single pulse: run rising starts counter and pulse leading edge.
// - Single pulse: external clock pin edge sets run automatically.
// - Pulse ends on run clear or A match; A match clears run, flags.
// - Single pulse: counter zeroed only at run rise; P and clear select ignored.
// - Mode 01 is capture; source select picks capture pin or clock pin.
// - Capture edge rising, falling or both; action 11 disables capture.
// - Capture copies counter into A value and raises a flag.
// - Capture mode counts freely from run rise until run falls.
// - Capture: P match zeroes counter with flag; P zero counts full range.
// - Compare operation with clear select high never sets P flag.
// - Compare: run rise restores initial level; only A events move pin.
// - Clear on A match if select high, else P match or overflow.
// - Compare A match drives pin high, low, toggles, or nothing.
// - Counter is 10 bits, wraps after 3ff.
`timescale 1ns/1ns
`default_nettype none
module pmt_timer
  import pmt_pkg::*;
#(
  parameter int DIV_W = PMT_DIV_W
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_input_pin_i,
  input wire logic external_clock_pin_i,
  output logic timer_out_o,
  output logic timer_out_oe_o,
  output logic compare_a_flag_o,
  output logic compare_p_flag_o
);
  typedef struct packed {
    logic [9:0] cnt;
    logic [9:0] compare_a_value;
    logic [9:0] compare_p_value;
    logic [DIV_W-1:0] div;
    logic run;
    pmt_mode_t mode;
    logic [1:0] io;
    logic oc;
    logic pol;
    logic capts;
    logic cclr;
    logic flag_a;
    logic flag_p;
    logic run_q;
    logic cap_q;
    logic ext_q;
    logic lvl;
    logic out;
    logic oe;
    logic ack;
    logic [31:0] rdat;
  } pmt_state_t;

  pmt_state_t s;
  pmt_state_t next_s;
  logic tick;

  pmt_tick_div #(.DIV_W(DIV_W)) u_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .div_i(s.div),
    .tick_o(tick)
  );

  function automatic logic [31:0] pmt_merge(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic [31:0] ctrl_word;
  logic [31:0] wr_word;
  logic [9:0] p_last;
  logic [10:0] period;
  logic match_a;
  logic match_p;
  logic run_rise;
  logic cap_src;
  logic cap_edge;
  logic ext_rise;
  logic pulse_mode;
  logic a_event;
  logic pwm_act;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] rd_word;
  logic a_hit;
  logic p_hit;
  logic p_wrap;
  logic duty_full;
  logic duty_on;
  logic pin_out;
  logic pin_oe;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[PMT_CTRL_RUN] = s.run;
    ctrl_word[PMT_CTRL_MODE +: 2] = s.mode;
    ctrl_word[PMT_CTRL_IO +: 2] = s.io;
    ctrl_word[PMT_CTRL_OC] = s.oc;
    ctrl_word[PMT_CTRL_POL] = s.pol;
    ctrl_word[PMT_CTRL_CAPTS] = s.capts;
    ctrl_word[PMT_CTRL_CCLR] = s.cclr;
  end

  // Read data select
  always_comb begin
    rd_word = '0;
    case (wb_adr_i)
      PMT_ADR_CTRL: rd_word = ctrl_word;
      PMT_ADR_CNT: rd_word = {22'h000000, s.cnt};
      PMT_ADR_COMPARE_A_VALUE: rd_word = {22'h000000, s.compare_a_value};
      PMT_ADR_COMPARE_P_VALUE: rd_word = {22'h000000, s.compare_p_value};
      PMT_ADR_FLAG: rd_word = {30'h00000000, s.flag_p, s.flag_a};
      PMT_ADR_DIV: rd_word = {{(32-DIV_W){1'b0}}, s.div};
      default: rd_word = '0;
    endcase
  end

  // Pin waveform
  always_comb begin
    if (s.compare_p_value == PMT_CCR_RST) begin
      period = PMT_PERIOD_FULL;
    end else begin
      period = {1'b0, s.compare_p_value};
    end
    duty_full = {1'b0, s.compare_a_value} >= period;
    duty_on = s.cnt < s.compare_a_value;
    pwm_act = s.run && (duty_full || duty_on);
    pin_oe = 1'b0;
    pin_out = 1'b0;
    case (s.mode)
      PMT_MODE_CMP: begin
        pin_oe = 1'b1;
        pin_out = s.lvl ^ s.pol;
      end
      PMT_MODE_PWM: begin
        pin_oe = 1'b1;
        case (s.io)
          PMT_IO_FORCE_LO: pin_out = 1'b0;
          PMT_IO_FORCE_HI: pin_out = 1'b1;
          PMT_IO_PWM: pin_out = (s.oc ? pwm_act : ~pwm_act) ^ s.pol;
          default: pin_out = (s.oc ? s.run : ~s.run) ^ s.pol;
        endcase
      end
      default: begin
        pin_oe = 1'b0;
        pin_out = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_s = s;
    wr_word = '0;
    a_event = 1'b0;
    bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;
    bus_rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s.ack;
    p_last = s.compare_p_value - 10'h001;
    match_a = s.cnt == s.compare_a_value;
    match_p = s.cnt == s.compare_p_value;
    a_hit = match_a && (s.compare_a_value != PMT_CCR_RST);
    p_hit = match_p && (s.compare_p_value != PMT_CCR_RST);
    p_wrap = s.cnt == p_last;
    run_rise = s.run & ~s.run_q;
    pulse_mode = (s.mode == PMT_MODE_PWM) && (s.io == PMT_IO_PULSE);
    if (s.capts) begin
      cap_src = external_clock_pin_i;
    end else begin
      cap_src = capture_input_pin_i;
    end
    ext_rise = external_clock_pin_i & ~s.ext_q;
    cap_edge = 1'b0;
    case (s.io)
      PMT_IO_RISE: cap_edge = cap_src & ~s.cap_q;
      PMT_IO_FALL: cap_edge = ~cap_src & s.cap_q;
      PMT_IO_BOTH: cap_edge = cap_src ^ s.cap_q;
      default: cap_edge = 1'b0;
    endcase

    // Bus slave: ack one cycle after request, write on the acked edge
    next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
    if (bus_rd) begin
      next_s.rdat = rd_word;
    end
    if (bus_wr) begin
      case (wb_adr_i)
        PMT_ADR_CTRL: begin
          wr_word = pmt_merge(ctrl_word, wb_dat_i, wb_sel_i);
          next_s.run = wr_word[PMT_CTRL_RUN];
          next_s.mode = pmt_mode_t'(wr_word[PMT_CTRL_MODE +: 2]);
          next_s.io = wr_word[PMT_CTRL_IO +: 2];
          next_s.oc = wr_word[PMT_CTRL_OC];
          next_s.pol = wr_word[PMT_CTRL_POL];
          next_s.capts = wr_word[PMT_CTRL_CAPTS];
          next_s.cclr = wr_word[PMT_CTRL_CCLR];
        end
        PMT_ADR_COMPARE_A_VALUE: begin
          wr_word = pmt_merge({22'h000000, s.compare_a_value}, wb_dat_i, wb_sel_i);
          next_s.compare_a_value = wr_word[9:0];
        end
        PMT_ADR_COMPARE_P_VALUE: begin
          wr_word = pmt_merge({22'h000000, s.compare_p_value}, wb_dat_i, wb_sel_i);
          next_s.compare_p_value = wr_word[9:0];
        end
        PMT_ADR_FLAG: begin
          wr_word = wb_dat_i & {32{wb_sel_i[0]}};
          next_s.flag_a = s.flag_a & ~wr_word[PMT_FLAG_A];
          next_s.flag_p = s.flag_p & ~wr_word[PMT_FLAG_P];
        end
        PMT_ADR_DIV: begin
          wr_word = pmt_merge({{(32-DIV_W){1'b0}}, s.div}, wb_dat_i, wb_sel_i);
          next_s.div = wr_word[DIV_W-1:0];
        end
        default: wr_word = '0;
      endcase
    end

    next_s.run_q = s.run;
    next_s.cap_q = cap_src;
    next_s.ext_q = external_clock_pin_i;

    if (run_rise) begin
      next_s.cnt = '0;
      next_s.lvl = s.oc;
    end else if (s.run && tick) begin
      case (s.mode)
        PMT_MODE_CMP, PMT_MODE_TMR: begin
          if (s.cclr) begin
            if (a_hit) begin
              next_s.cnt = '0;
            end else begin
              next_s.cnt = s.cnt + 10'h001;
            end
          end else if (p_hit) begin
            next_s.cnt = '0;
            next_s.flag_p = 1'b1;
          end else if (s.cnt == PMT_CNT_MAX && s.compare_p_value == PMT_CCR_RST) begin
            next_s.cnt = '0;
            next_s.flag_p = 1'b1;
          end else begin
            next_s.cnt = s.cnt + 10'h001;
          end
          a_event = a_hit;
          if (a_event) begin
            next_s.flag_a = 1'b1;
            case (s.io)
              PMT_IO_LOW: next_s.lvl = 1'b0;
              PMT_IO_HIGH: next_s.lvl = 1'b1;
              PMT_IO_TOG: next_s.lvl = ~s.lvl;
              default: next_s.lvl = s.lvl;
            endcase
          end
        end
        PMT_MODE_PWM: begin
          if (pulse_mode) begin
            next_s.cnt = s.cnt + 10'h001;
            if (match_a) begin
              next_s.run = 1'b0;
              next_s.flag_a = 1'b1;
            end
          end else begin
            if (p_wrap) begin
              next_s.cnt = '0;
              next_s.flag_p = 1'b1;
            end else begin
              next_s.cnt = s.cnt + 10'h001;
            end
            if (match_a) begin
              next_s.flag_a = 1'b1;
            end
          end
        end
        PMT_MODE_CAP: begin
          if (p_hit) begin
            next_s.cnt = '0;
            next_s.flag_p = 1'b1;
          end else begin
            next_s.cnt = s.cnt + 10'h001;
          end
        end
        default: next_s.cnt = s.cnt;
      endcase
    end

    if (s.mode == PMT_MODE_CAP && cap_edge) begin
      next_s.compare_a_value = s.cnt;
      next_s.flag_a = 1'b1;
    end
    if (pulse_mode && ext_rise) begin
      next_s.run = 1'b1;
    end

    next_s.out = pin_out;
    next_s.oe = pin_oe;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign timer_out_o = s.out;
  assign timer_out_oe_o = s.oe;
  assign compare_a_flag_o = s.flag_a;
  assign compare_p_flag_o = s.flag_p;
endmodule
`default_nettype wire

// >>> pmt_timer_asserts.sv
// Purpose: Port checks for pmt_timer.
// Assumes: Bound to the top module.
// Notes: Bus and flag relations only.
`timescale 1ns/1ns
`default_nettype none
module pmt_timer_asserts
  import pmt_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic timer_out_o,
  input wire logic compare_a_flag_o,
  input wire logic compare_p_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic rd;
  logic clr;
  assign rd = wb_ack_o && !wb_we_i;
  assign clr = wb_ack_o && wb_we_i && wb_adr_i == PMT_ADR_FLAG && wb_sel_i[0];
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (rd && wb_adr_i > PMT_ADR_DIV |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_cnt_width: assert property (rd && wb_adr_i == PMT_ADR_CNT |->
    wb_dat_o[31:10] == 22'h0) else $error("counter wider than 10 bits");
  a_flag_read: assert property (rd && wb_adr_i == PMT_ADR_FLAG |->
    wb_dat_o == {30'h0, $past(compare_p_flag_o), $past(compare_a_flag_o)})
    else $error("flag read mismatch");
  a_flag_a_hold: assert property ($fell(compare_a_flag_o) |-> $past(clr && wb_dat_i[0]))
    else $error("flag a lost");
  a_flag_p_hold: assert property ($fell(compare_p_flag_o) |-> $past(clr && wb_dat_i[1]))
    else $error("flag p lost");
  a_rdat_hold: assert property ($changed(wb_dat_o) |-> rd) else $error("read data moved");
  c_flag_a: cover property ($rose(compare_a_flag_o));
  c_flag_p: cover property ($rose(compare_p_flag_o));
  c_pin_rise: cover property ($rose(timer_out_o));
endmodule
`default_nettype wire

// >>> pmt_pin_model.sv
// Purpose: Capture and trigger pins with output load.
// Assumes: Pins change after a rising edge.
// Notes: Released output reads low.
`timescale 1ns/1ns
`default_nettype none
module pmt_pin_model (
  input wire logic clk_i,
  input wire logic out_i,
  input wire logic oe_i,
  output logic cap_o,
  output logic ext_o,
  output logic level_o
);
  initial begin
    cap_o = 1'b0;
    ext_o = 1'b0;
  end
  assign level_o = oe_i ? out_i : 1'b0;
  // Pulse on capture or clock pin
  task pulse(input logic ext);
    @(posedge clk_i);
    if (ext) ext_o <= 1'b1;
    else cap_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    ext_o <= 1'b0;
    cap_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> test_pmt_timer.sv
// Purpose: Register level test of pmt_timer.
// Assumes: One clock, divider left at zero.
// Notes: Single pulse width checked in a range; other high times checked exactly.
`timescale 1ns/1ns
`default_nettype none
module test_pmt_timer
  import pmt_pkg::*;
;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic [31:0] wb_dat_o, q, v, k;
  logic wb_ack_o, tout, toe, fa, fp, cap, ext, load;
  int miscompares = 0;
  int total_checks = 0;
  always #5 clk_i = ~clk_i;
  pmt_timer DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .capture_input_pin_i(cap), .external_clock_pin_i(ext),
    .timer_out_o(tout), .timer_out_oe_o(toe), .compare_a_flag_o(fa), .compare_p_flag_o(fp));
  pmt_pin_model PINS (.clk_i(clk_i), .out_i(tout), .oe_i(toe), .cap_o(cap), .ext_o(ext),
    .level_o(load));
  task complete_run;
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (e !== g) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n;
    @(posedge clk_i);
    adr <= a;
    wdat <= d;
    we <= w;
    cyc <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) begin
      miscompares++;
      complete_run;
    end
    cyc <= 1'b0;
  endtask
  task hi(input int n);
    k = 32'h0;
    repeat (2) @(posedge clk_i);
    repeat (n) begin
      @(posedge clk_i);
      if (tout === 1'b1) k++;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    xfer(PMT_ADR_CTRL, 0, 0);
    check("ctrl", 32'h0, q);
    xfer(8'h20, 0, 0);
    check("unmapped", 32'h0, q);
    xfer(PMT_ADR_COMPARE_A_VALUE, 32'h5, 1);
    xfer(PMT_ADR_CTRL, 32'h107, 1);
    repeat (40) @(posedge clk_i);
    check("oe", 32'h0, {toe, load});
    xfer(PMT_ADR_FLAG, 0, 0);
    check("tmr flags", 32'h1, q);
    check("flag pins", 32'h1, {fp, fa});
    xfer(PMT_ADR_CNT, 0, 0);
    check("cnt clear a", 32'h1, q < 6);
    xfer(PMT_ADR_CTRL, 32'h106, 1);
    xfer(PMT_ADR_CNT, 0, 0);
    v = q;
    xfer(PMT_ADR_CNT, 0, 0);
    check("cnt hold", v, q);
    xfer(PMT_ADR_CTRL, 32'h129, 1);
    hi(16);
    check("cmp low", 32'h6, k);
    check("cmp oe", 32'h1, toe);
    xfer(PMT_ADR_CTRL, 32'h128, 1);
    xfer(PMT_ADR_FLAG, 32'h3, 1);
    xfer(PMT_ADR_FLAG, 0, 0);
    check("flag clr", 32'h0, q);
    check("flag pins clr", 32'h0, {fp, fa});
    xfer(PMT_ADR_COMPARE_P_VALUE, 32'h4, 1);
    xfer(PMT_ADR_COMPARE_A_VALUE, 32'h1, 1);
    xfer(PMT_ADR_CTRL, 32'h135, 1);
    hi(16);
    check("duty", 32'h4, k);
    xfer(PMT_ADR_FLAG, 0, 0);
    check("pwm flags", 32'h3, q);
    xfer(PMT_ADR_COMPARE_A_VALUE, 32'h8, 1);
    hi(16);
    check("full", 32'h10, k);
    xfer(PMT_ADR_CTRL, 32'h75, 1);
    hi(16);
    check("pol", 32'h0, k);
    xfer(PMT_ADR_CTRL, 32'h55, 1);
    hi(16);
    check("low act", 32'h10, k);
    xfer(PMT_ADR_CTRL, 32'h2d, 1);
    hi(16);
    check("force hi", 32'h10, k);
    xfer(PMT_ADR_CNT, 0, 0);
    v = q;
    xfer(PMT_ADR_CNT, 0, 0);
    check("runs", 32'h1, q !== v);
    xfer(PMT_ADR_CTRL, 32'h25, 1);
    hi(16);
    check("force lo", 32'h0, k);
    xfer(PMT_ADR_CTRL, 32'h34, 1);
    xfer(PMT_ADR_COMPARE_P_VALUE, 32'h0, 1);
    xfer(PMT_ADR_COMPARE_A_VALUE, 32'h100, 1);
    xfer(PMT_ADR_CTRL, 32'h35, 1);
    hi(2048);
    check("p zero", 32'h200, k);
    xfer(PMT_ADR_CTRL, 32'h3c, 1);
    xfer(PMT_ADR_FLAG, 32'h3, 1);
    xfer(PMT_ADR_COMPARE_A_VALUE, 32'ha, 1);
    PINS.pulse(1'b1);
    hi(30);
    check("pulse", 32'h1, k > 3 && k < 12);
    xfer(PMT_ADR_CTRL, 0, 0);
    check("run off", 32'h3c, q);
    xfer(PMT_ADR_FLAG, 0, 0);
    check("sp flag", 32'h1, q[0]);
    xfer(PMT_ADR_CNT, 0, 0);
    check("cnt kept", 32'h1, q != 0);
    xfer(PMT_ADR_CTRL, 32'h3d, 1);
    xfer(PMT_ADR_CNT, 0, 0);
    check("cnt zero", 32'h1, q < 5);
    xfer(PMT_ADR_CTRL, 32'h2, 1);
    xfer(PMT_ADR_COMPARE_P_VALUE, 32'h64, 1);
    xfer(PMT_ADR_FLAG, 32'h3, 1);
    for (int e = 0; e < 4; e++) begin
      xfer(PMT_ADR_COMPARE_A_VALUE, 32'h3ff, 1);
      xfer(PMT_ADR_CTRL, 32'h3 | (e << 3), 1);
      repeat (20) @(posedge clk_i);
      PINS.pulse(1'b0);
      xfer(PMT_ADR_COMPARE_A_VALUE, 0, 0);
      check("capture", e != 3, q !== 32'h3ff);
    end
    xfer(PMT_ADR_FLAG, 0, 0);
    check("cap flags", 32'h3, q);
    xfer(PMT_ADR_COMPARE_A_VALUE, 32'h3ff, 1);
    xfer(PMT_ADR_CTRL, 32'h83, 1);
    PINS.pulse(1'b0);
    xfer(PMT_ADR_COMPARE_A_VALUE, 0, 0);
    check("src pin", 32'h3ff, q);
    PINS.pulse(1'b1);
    xfer(PMT_ADR_COMPARE_A_VALUE, 0, 0);
    check("src clk", 32'h1, q < 100);
    xfer(PMT_ADR_CNT, 0, 0);
    check("cap wrap", 32'h1, q < 100);
    complete_run;
  end
endmodule
bind pmt_timer pmt_timer_asserts CHK (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer_out_o(timer_out_o), .compare_a_flag_o(compare_a_flag_o),
  .compare_p_flag_o(compare_p_flag_o));
`default_nettype wire
